// ===== pkg/sofs_consts.svh
// register offsets, reset values, function codes and widths of the output selector
`ifndef SOFS_CONSTS_SVH
`define SOFS_CONSTS_SVH

`define SOFS_OFF_SEL0 8'h00
`define SOFS_OFF_SEL1 8'h04
`define SOFS_OFF_SEL2 8'h08
`define SOFS_OFF_SEL3 8'h0c
`define SOFS_OFF_SWOUT 8'h10
`define SOFS_OFF_STANDSTILL_OUT_THR 8'h14
`define SOFS_OFF_VELOCITY_REACHED_OUT_THR 8'h18
`define SOFS_OFF_POS_TOL 8'h1c
`define SOFS_OFF_OVL_THR 8'h20
`define SOFS_OFF_NEG_LIM 8'h24
`define SOFS_OFF_POS_LIM 8'h28
`define SOFS_OFF_NEG_RAMP 8'h2c
`define SOFS_OFF_POS_RAMP 8'h30
`define SOFS_OFF_STATE 8'h34
`define SOFS_OFF_IRQ_STAT 8'h38
`define SOFS_OFF_IRQ_MASK 8'h3c

`define SOFS_RST_SEL0 8'h01
`define SOFS_RST_SELN 8'h00

`define SOFS_FN_READY 8'h01
`define SOFS_FN_POWER 8'h02
`define SOFS_FN_STANDSTILL 8'h03
`define SOFS_FN_VEL_REACHED 8'h04
`define SOFS_FN_MOVE_DONE 8'h05
`define SOFS_FN_TORQUE_LIM 8'h06
`define SOFS_FN_ERROR 8'h07
`define SOFS_FN_BRAKE 8'h08
`define SOFS_FN_HOMED 8'h09
`define SOFS_FN_OVERLOAD 8'h10
`define SOFS_FN_ALERT 8'h11
`define SOFS_FN_NEG_SOFT 8'h13
`define SOFS_FN_POS_SOFT 8'h14
`define SOFS_FN_CMD_DONE 8'h15
`define SOFS_FN_PROBE1 8'h16
`define SOFS_FN_PROBE2 8'h18
`define SOFS_FN_SW_BASE 8'h30
`define SOFS_FN_SW_LAST 8'h33

`define SOFS_EV_W 8
`define SOFS_N_OUT 4

`endif

// ===== pkg/sofs_pkg.sv
// types shared by the output function selector
package sofs_pkg;

	// status sources delivered by the motion and state logic
	typedef struct packed {
		logic fault_state;
		logic op_enabled;
		logic at_target;
		logic torque_at_limit;
		logic brake_release;
		logic homing_done;
		logic hw_limit;
		logic undervoltage;
		logic nodeguard_alert;
		logic operational_stop;
		logic cmd_done;
		logic probe_one_done;
		logic probe_two_done;
	} sofs_src_t;

	// evaluated conditions, one per function
	typedef struct packed {
		logic ready;
		logic power;
		logic standstill;
		logic vel_reached;
		logic move_done;
		logic torque_lim;
		logic error;
		logic brake;
		logic homed;
		logic overload;
		logic alert;
		logic neg_soft;
		logic pos_soft;
		logic cmd_done;
		logic probe1;
		logic probe2;
	} sofs_cond_t;

	typedef enum logic [1:0] {
		SOFS_IDLE,
		SOFS_ACCESS
	} sofs_bus_st_t;

endpackage

// ===== core/sofs_selector.sv
// four digital outputs with selectable drive status functions, apb register file
`timescale 1ns/10ps
`default_nettype none
`include "sofs_consts.svh"
// What this block does
// - four digital outputs, each with its own function select register
// - reset puts servo ready on the first output, others unassigned
// - code 01h active while the drive is not in fault
// - code 02h active only in operation enabled
// - code 03h active while velocity is below the zero speed threshold
// - code 04h active while velocity exceeds the speed reached threshold
// - code 05h active when at target and target deviation lies within tolerance
// - code 06h active when torque has reached its limit
// - code 07h active while the drive is in fault
// - code 08h carries the holding brake control signal
// - code 09h active once homing has completed
// - code 10h active when load reaches the overload threshold
// - code 11h active on limit switch, undervoltage, node guard or stop
// - codes 13h/14h on soft limits, which also alert and start decel
// - code 15h active when the internal command sequence completed
// - codes 16h/18h active when probe one or two capture completed
// - codes 30h to 33h show bits 0 to 3 of the software setting
module sofs_selector #(
	parameter int VEL_W = 16,
	parameter int POS_W = 32,
	parameter int LOAD_W = 16,
	parameter int RAMP_W = 16
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sofs_pkg::sofs_src_t drive_src,
	input wire logic [VEL_W-1:0] velocity_abs,
	input wire logic [POS_W-1:0] position_error_abs,
	input wire logic signed [POS_W-1:0] position_actual,
	input wire logic [LOAD_W-1:0] motor_load,
	output logic [3:0] digital_out,
	output logic decel_request,
	output logic [RAMP_W-1:0] decel_ramp,
	output logic irq
);
	import sofs_pkg::*;

	logic [7:0] sel_r [`SOFS_N_OUT];
	logic [3:0] sw_output_setting_r;
	logic [VEL_W-1:0] zero_speed_threshold_r;
	logic [VEL_W-1:0] speed_reached_threshold_r;
	logic [POS_W-1:0] position_done_tolerance_r;
	logic [LOAD_W-1:0] overload_threshold_r;
	logic signed [POS_W-1:0] neg_soft_limit_position_r;
	logic signed [POS_W-1:0] pos_soft_limit_position_r;
	logic [RAMP_W-1:0] neg_limit_decel_ramp_r;
	logic [RAMP_W-1:0] pos_limit_decel_ramp_r;
	logic [`SOFS_EV_W-1:0] irq_stat_r;
	logic [`SOFS_EV_W-1:0] irq_stat_nxt;
	logic [`SOFS_EV_W-1:0] irq_mask_r;
	logic [`SOFS_EV_W-1:0] ev_level;
	logic [`SOFS_EV_W-1:0] ev_level_r;
	logic [3:0] dout_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic pready_r;
	logic pslverr_r;
	logic unmapped;
	logic decel_req_r;
	logic [RAMP_W-1:0] decel_ramp_r;
	logic irq_r;
	logic wr_en;
	logic rd_en;
	sofs_bus_st_t bus_st_r;
	sofs_cond_t cond;

	assign prdata = rdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign digital_out = dout_r;
	assign decel_request = decel_req_r;
	assign decel_ramp = decel_ramp_r;
	assign irq = irq_r;

	// a transfer completes on the edge where the access phase meets pready
	assign wr_en = psel && penable && pready_r && pwrite && !pslverr_r;
	assign rd_en = psel && penable && pready_r && !pwrite && !pslverr_r;

	// status conditions
	always_comb begin
		cond.ready = !drive_src.fault_state;
		cond.power = drive_src.op_enabled;
		cond.standstill = velocity_abs < zero_speed_threshold_r;
		cond.vel_reached = velocity_abs > speed_reached_threshold_r;
		cond.move_done = drive_src.at_target &&
			(position_error_abs <= position_done_tolerance_r);
		cond.torque_lim = drive_src.torque_at_limit;
		cond.error = drive_src.fault_state;
		cond.brake = drive_src.brake_release;
		cond.homed = drive_src.homing_done;
		cond.overload = motor_load >= overload_threshold_r;
		cond.neg_soft = position_actual <= neg_soft_limit_position_r;
		cond.pos_soft = position_actual >= pos_soft_limit_position_r;
		// soft limit reach is an alert too
		cond.alert = drive_src.hw_limit || drive_src.undervoltage ||
			drive_src.nodeguard_alert || drive_src.operational_stop ||
			cond.neg_soft || cond.pos_soft;
		cond.cmd_done = drive_src.cmd_done;
		cond.probe1 = drive_src.probe_one_done;
		cond.probe2 = drive_src.probe_two_done;
	end

	function automatic logic pick(input logic [7:0] code, input sofs_cond_t c,
		input logic [3:0] sw);
		logic v;
		v = 1'b0;
		case (code)
			`SOFS_FN_READY: v = c.ready;
			`SOFS_FN_POWER: v = c.power;
			`SOFS_FN_STANDSTILL: v = c.standstill;
			`SOFS_FN_VEL_REACHED: v = c.vel_reached;
			`SOFS_FN_MOVE_DONE: v = c.move_done;
			`SOFS_FN_TORQUE_LIM: v = c.torque_lim;
			`SOFS_FN_ERROR: v = c.error;
			`SOFS_FN_BRAKE: v = c.brake;
			`SOFS_FN_HOMED: v = c.homed;
			`SOFS_FN_OVERLOAD: v = c.overload;
			`SOFS_FN_ALERT: v = c.alert;
			`SOFS_FN_NEG_SOFT: v = c.neg_soft;
			`SOFS_FN_POS_SOFT: v = c.pos_soft;
			`SOFS_FN_CMD_DONE: v = c.cmd_done;
			`SOFS_FN_PROBE1: v = c.probe1;
			`SOFS_FN_PROBE2: v = c.probe2;
			`SOFS_FN_SW_BASE: v = sw[0];
			8'h31: v = sw[1];
			8'h32: v = sw[2];
			`SOFS_FN_SW_LAST: v = sw[3];
			// unassigned, 0ah-0fh, 12h, 17h, 19h-2fh, 34h and up stay low
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	// one registered output per selector; one cycle from source to pin
	// a single process owns the whole output vector, so no bit has two writers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dout_r <= 4'h0;
		end else begin
			for (int i = 0; i < `SOFS_N_OUT; i++) begin
				dout_r[i] <= pick(sel_r[i], cond, sw_output_setting_r);
			end
		end
	end

	// function selects
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_r[0] <= `SOFS_RST_SEL0;
			sel_r[1] <= `SOFS_RST_SELN;
			sel_r[2] <= `SOFS_RST_SELN;
			sel_r[3] <= `SOFS_RST_SELN;
		end else if (wr_en) begin
			case (paddr)
				`SOFS_OFF_SEL0: sel_r[0] <= pwdata[7:0];
				`SOFS_OFF_SEL1: sel_r[1] <= pwdata[7:0];
				`SOFS_OFF_SEL2: sel_r[2] <= pwdata[7:0];
				`SOFS_OFF_SEL3: sel_r[3] <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// configuration registers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_output_setting_r <= 4'h0;
			zero_speed_threshold_r <= '0;
			speed_reached_threshold_r <= '0;
			position_done_tolerance_r <= '0;
			overload_threshold_r <= '1;
			neg_soft_limit_position_r <= {1'b1, {(POS_W-1){1'b0}}};
			pos_soft_limit_position_r <= {1'b0, {(POS_W-1){1'b1}}};
			neg_limit_decel_ramp_r <= '0;
			pos_limit_decel_ramp_r <= '0;
			irq_mask_r <= '0;
		end else if (wr_en) begin
			case (paddr)
				`SOFS_OFF_SWOUT: sw_output_setting_r <= pwdata[3:0];
				`SOFS_OFF_STANDSTILL_OUT_THR: zero_speed_threshold_r <= pwdata[VEL_W-1:0];
				`SOFS_OFF_VELOCITY_REACHED_OUT_THR: speed_reached_threshold_r <= pwdata[VEL_W-1:0];
				`SOFS_OFF_POS_TOL: position_done_tolerance_r <= pwdata[POS_W-1:0];
				`SOFS_OFF_OVL_THR: overload_threshold_r <= pwdata[LOAD_W-1:0];
				`SOFS_OFF_NEG_LIM: neg_soft_limit_position_r <= pwdata[POS_W-1:0];
				`SOFS_OFF_POS_LIM: pos_soft_limit_position_r <= pwdata[POS_W-1:0];
				`SOFS_OFF_NEG_RAMP: neg_limit_decel_ramp_r <= pwdata[RAMP_W-1:0];
				`SOFS_OFF_POS_RAMP: pos_limit_decel_ramp_r <= pwdata[RAMP_W-1:0];
				`SOFS_OFF_IRQ_MASK: irq_mask_r <= pwdata[`SOFS_EV_W-1:0];
				default: ;
			endcase
		end
	end

	// soft limit deceleration request; negative side wins if both are reached
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			decel_req_r <= 1'b0;
			decel_ramp_r <= '0;
		end else begin
			decel_req_r <= cond.neg_soft || cond.pos_soft;
			if (cond.neg_soft) begin
				decel_ramp_r <= neg_limit_decel_ramp_r;
			end else if (cond.pos_soft) begin
				decel_ramp_r <= pos_limit_decel_ramp_r;
			end
		end
	end

	// events: rising edges of fault, soft limits, alert and completion flags
	assign ev_level = {cond.probe2, cond.probe1, cond.cmd_done, cond.homed,
		cond.alert, cond.pos_soft, cond.neg_soft, cond.error};

	always_comb begin
		irq_stat_nxt = irq_stat_r;
		if (rd_en && paddr == `SOFS_OFF_IRQ_STAT) begin
			irq_stat_nxt = '0;
		end
		// a new event in the clearing cycle survives the read
		irq_stat_nxt = irq_stat_nxt | (ev_level & ~ev_level_r);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ev_level_r <= '0;
			irq_stat_r <= '0;
			irq_r <= 1'b0;
		end else begin
			ev_level_r <= ev_level;
			irq_stat_r <= irq_stat_nxt;
			irq_r <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	// read mux, evaluated during the setup cycle
	always_comb begin
		rdata_nxt = 32'h0;
		unmapped = 1'b0;
		case (paddr)
			`SOFS_OFF_SEL0: rdata_nxt = {24'h0, sel_r[0]};
			`SOFS_OFF_SEL1: rdata_nxt = {24'h0, sel_r[1]};
			`SOFS_OFF_SEL2: rdata_nxt = {24'h0, sel_r[2]};
			`SOFS_OFF_SEL3: rdata_nxt = {24'h0, sel_r[3]};
			`SOFS_OFF_SWOUT: rdata_nxt = {28'h0, sw_output_setting_r};
			`SOFS_OFF_STANDSTILL_OUT_THR: rdata_nxt = 32'(zero_speed_threshold_r);
			`SOFS_OFF_VELOCITY_REACHED_OUT_THR: rdata_nxt = 32'(speed_reached_threshold_r);
			`SOFS_OFF_POS_TOL: rdata_nxt = 32'(position_done_tolerance_r);
			`SOFS_OFF_OVL_THR: rdata_nxt = 32'(overload_threshold_r);
			`SOFS_OFF_NEG_LIM: rdata_nxt = 32'(unsigned'(neg_soft_limit_position_r));
			`SOFS_OFF_POS_LIM: rdata_nxt = 32'(unsigned'(pos_soft_limit_position_r));
			`SOFS_OFF_NEG_RAMP: rdata_nxt = 32'(neg_limit_decel_ramp_r);
			`SOFS_OFF_POS_RAMP: rdata_nxt = 32'(pos_limit_decel_ramp_r);
			`SOFS_OFF_STATE: rdata_nxt = {27'h0, decel_req_r, dout_r};
			`SOFS_OFF_IRQ_STAT: rdata_nxt = 32'(irq_stat_r);
			`SOFS_OFF_IRQ_MASK: rdata_nxt = 32'(irq_mask_r);
			default: unmapped = 1'b1;
		endcase
	end

	// apb handshake: pready rises for exactly one access cycle, no wait states
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_st_r <= SOFS_IDLE;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			rdata_r <= 32'h0;
		end else begin
			case (bus_st_r)
				SOFS_IDLE: begin
					if (psel && !penable) begin
						bus_st_r <= SOFS_ACCESS;
						pready_r <= 1'b1;
						pslverr_r <= unmapped;
						rdata_r <= pwrite ? 32'h0 : rdata_nxt;
					end
				end
				SOFS_ACCESS: begin
					bus_st_r <= SOFS_IDLE;
					pready_r <= 1'b0;
					pslverr_r <= 1'b0;
					rdata_r <= 32'h0;
				end
				default: begin
					bus_st_r <= SOFS_IDLE;
					pready_r <= 1'b0;
					pslverr_r <= 1'b0;
				end
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_done;
		pready_r ##1 !pready_r;
	endsequence

	property p_ready_out;
		(sel_r[0] == `SOFS_FN_READY) |=> (dout_r[0] == !$past(drive_src.fault_state));
	endproperty
	a_ready_out: assert property (p_ready_out) else $error("ready output wrong");

	property p_power_out;
		(sel_r[1] == `SOFS_FN_POWER) |=> (dout_r[1] == $past(drive_src.op_enabled));
	endproperty
	a_power_out: assert property (p_power_out) else $error("power output wrong");

	property p_standstill;
		(sel_r[2] == `SOFS_FN_STANDSTILL && velocity_abs < zero_speed_threshold_r)
			|=> dout_r[2];
	endproperty
	a_standstill: assert property (p_standstill) else $error("standstill missed");

	property p_error_out;
		(sel_r[3] == `SOFS_FN_ERROR) |=> (dout_r[3] == $past(drive_src.fault_state));
	endproperty
	a_error_out: assert property (p_error_out) else $error("error output wrong");

	property p_sw_bit;
		(sel_r[0] >= `SOFS_FN_SW_BASE && sel_r[0] <= `SOFS_FN_SW_LAST)
			|=> (dout_r[0] == $past(sw_output_setting_r[sel_r[0][1:0]]));
	endproperty
	a_sw_bit: assert property (p_sw_bit) else $error("software bit not shown");

	property p_reserved;
		(sel_r[1] == 8'h12 || sel_r[1] == 8'h17 || sel_r[1] > `SOFS_FN_SW_LAST)
			|=> !dout_r[1];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code drove out");

	property p_soft_decel;
		(position_actual >= pos_soft_limit_position_r &&
			position_actual > neg_soft_limit_position_r)
			|=> (decel_req_r && decel_ramp_r == $past(pos_limit_decel_ramp_r));
	endproperty
	a_soft_decel: assert property (p_soft_decel) else $error("soft limit decel missing");

	property p_apb_answer;
		s_setup |=> s_done;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

	property p_read_clear;
		(rd_en && paddr == `SOFS_OFF_IRQ_STAT && (ev_level & ~ev_level_r) == '0)
			|=> irq_stat_r == '0 ##1 irq_r == |(irq_stat_r & irq_mask_r);
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("status not cleared");

endmodule
`default_nettype wire

// ===== test/sofs_load.sv
// far-side load model: equipment latching the four digital outputs
`timescale 1ns/10ps
`default_nettype none
module sofs_load #(
	parameter int BRAKE_PIN = 3
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [3:0] pins,
	output logic [3:0] seen,
	output logic brake_held
);
	// wired equipment sees the pins one edge late, like any input latch
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			seen <= 4'h0;
		end else begin
			seen <= pins;
		end
	end
	// brake stays engaged unless its wired output commands release
	assign brake_held = !seen[BRAKE_PIN];
endmodule
`default_nettype wire

// ===== test/sofs_selector_test.sv
// self-checking bench for the output function selector
`timescale 1ns/10ps
`default_nettype none
`include "sofs_consts.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
	$display("FAIL %s expected %h seen %h", nm, e, g); end end
module sofs_selector_test;
	import sofs_pkg::*;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, decel_request, irq, brake_held, err;
	sofs_src_t drive_src = '0;
	logic [15:0] velocity_abs = 16'h0;
	logic [15:0] motor_load = 16'h0;
	logic [31:0] position_error_abs = 32'h0;
	logic signed [31:0] position_actual = 32'sh0;
	logic [15:0] decel_ramp, zthr, sthr, othr, nramp, pramp;
	logic [3:0] digital_out, seen, sw;
	logic [31:0] lfsr = 32'h00013c58;
	logic [31:0] rd, r, tol;
	logic signed [31:0] nlim, plim;
	logic [7:0] code, sel [4];
	int o;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;

	sofs_selector i_sofs_selector (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_src(drive_src),
		.velocity_abs(velocity_abs), .position_error_abs(position_error_abs),
		.position_actual(position_actual), .motor_load(motor_load),
		.digital_out(digital_out), .decel_request(decel_request),
		.decel_ramp(decel_ramp), .irq(irq));
	sofs_load #(.BRAKE_PIN(0)) i_sofs_load (.core_clk(core_clk), .rst_b(rst_b),
		.pins(digital_out), .seen(seen), .brake_held(brake_held));

	always #5 core_clk = ~core_clk;

	// the whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			report_and_stop();
		end
	end

	function automatic logic [31:0] rnd();
		for (int k = 0; k < 32; k++) begin
			lfsr = lfsr[0] ? ((lfsr >> 1) ^ 32'h80200003) : (lfsr >> 1);
		end
		return lfsr;
	endfunction

	function automatic logic exp_bit(input logic [7:0] c);
		logic nr, pr;
		nr = position_actual <= nlim;
		pr = position_actual >= plim;
		case (c)
			`SOFS_FN_READY: return !drive_src.fault_state;
			`SOFS_FN_POWER: return drive_src.op_enabled;
			`SOFS_FN_STANDSTILL: return velocity_abs < zthr;
			`SOFS_FN_VEL_REACHED: return velocity_abs > sthr;
			`SOFS_FN_MOVE_DONE: return drive_src.at_target && position_error_abs <= tol;
			`SOFS_FN_TORQUE_LIM: return drive_src.torque_at_limit;
			`SOFS_FN_ERROR: return drive_src.fault_state;
			`SOFS_FN_BRAKE: return drive_src.brake_release;
			`SOFS_FN_HOMED: return drive_src.homing_done;
			`SOFS_FN_OVERLOAD: return motor_load >= othr;
			`SOFS_FN_ALERT: return drive_src.hw_limit | drive_src.undervoltage |
				drive_src.nodeguard_alert | drive_src.operational_stop | nr | pr;
			`SOFS_FN_NEG_SOFT: return nr;
			`SOFS_FN_POS_SOFT: return pr;
			`SOFS_FN_CMD_DONE: return drive_src.cmd_done;
			`SOFS_FN_PROBE1: return drive_src.probe_one_done;
			`SOFS_FN_PROBE2: return drive_src.probe_two_done;
			default: return (c >= 8'h30 && c <= 8'h33) ? sw[c[1:0]] : 1'b0;
		endcase
	endfunction

	// one apb transfer; read data and error land in rd and err
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		#1;
		`CHK("outputs after reset", 4'h1, digital_out)
		for (int i = 0; i < 4; i++) begin
			sel[i] = (i == 0) ? `SOFS_RST_SEL0 : `SOFS_RST_SELN;
			apb(1'b0, 8'(i * 4), 32'h0);
			`CHK("select reset", {24'h0, sel[i]}, rd)
		end
		apb(1'b0, `SOFS_OFF_OVL_THR, 32'h0);
		`CHK("overload reset", 32'h0000ffff, rd)
		apb(1'b1, 8'h40, 32'hffffffff);
		`CHK("unmapped write", 1'b1, err)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped read", {1'b1, 32'h0}, {err, rd})
		r = rnd();
		zthr = r[15:0];
		sthr = r[31:16];
		r = rnd();
		othr = r[15:0];
		tol = {16'h0, r[31:16]};
		r = rnd();
		nramp = r[15:0];
		pramp = r[31:16];
		nlim = 32'hfffffc18;
		plim = 32'h000003e8;
		apb(1'b1, `SOFS_OFF_STANDSTILL_OUT_THR, {16'h0, zthr});
		apb(1'b1, `SOFS_OFF_VELOCITY_REACHED_OUT_THR, {16'h0, sthr});
		apb(1'b1, `SOFS_OFF_OVL_THR, {16'h0, othr});
		apb(1'b1, `SOFS_OFF_POS_TOL, tol);
		apb(1'b1, `SOFS_OFF_NEG_LIM, nlim);
		apb(1'b1, `SOFS_OFF_POS_LIM, plim);
		apb(1'b1, `SOFS_OFF_NEG_RAMP, {16'h0, nramp});
		apb(1'b1, `SOFS_OFF_POS_RAMP, {16'h0, pramp});
		// every code once, then reserved codes above 3fh
		for (int c = 0; c < 72; c++) begin
			r = rnd();
			code = (c < 64) ? 8'(c) : (8'h40 | r[7:0]);
			@(posedge core_clk);
			drive_src <= sofs_src_t'(r[20:8]);
			velocity_abs <= (c == 3) ? 16'h0 : r[31:16];
			r = rnd();
			position_error_abs <= {16'h0, r[15:0]};
			motor_load <= r[31:16];
			position_actual <= {{21{r[10]}}, r[10:0]};
			r = rnd();
			sw = r[3:0];
			apb(1'b1, `SOFS_OFF_SWOUT, {28'h0, sw});
			// codes 02h and 03h go to outputs 1 and 2 instead of 2 and 3, where assertions watch
			o = (c == 2 || c == 3) ? c - 1 : c % 4;
			sel[o] = code;
			apb(1'b1, 8'(o * 4), {24'h0, code});
			@(posedge core_clk);
			#1;
			for (int i = 0; i < 4; i++) begin
				`CHK("output", exp_bit(sel[i]), digital_out[i])
			end
			`CHK("decel", position_actual <= nlim || position_actual >= plim, decel_request)
			if (position_actual <= nlim) begin
				`CHK("neg ramp", nramp, decel_ramp)
			end else if (position_actual >= plim) begin
				`CHK("pos ramp", pramp, decel_ramp)
			end
			// the load latches the pins one edge late
			@(posedge core_clk);
			#1;
			`CHK("brake held", !exp_bit(sel[0]), brake_held)
		end
		// fault entry raises the interrupt only while unmasked
		for (int m = 1; m >= 0; m--) begin
			@(posedge core_clk);
			drive_src <= '0;
			position_actual <= 32'sh0;
			apb(1'b1, `SOFS_OFF_IRQ_MASK, 32'(m));
			apb(1'b0, `SOFS_OFF_IRQ_STAT, 32'h0);
			@(posedge core_clk);
			#1;
			`CHK("irq idle", 1'b0, irq)
			@(posedge core_clk);
			drive_src.fault_state <= 1'b1;
			@(posedge core_clk);
			#1;
			`CHK("irq raised", 1'(m), irq)
			apb(1'b0, `SOFS_OFF_IRQ_STAT, 32'h0);
			`CHK("fault status", 1'b1, rd[0])
			@(posedge core_clk);
			#1;
			`CHK("irq cleared", 1'b0, irq)
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
